//--- design/sbc_timing_map.svh
/*
 Constants of the mode and wake sequencer: clock rate, times in their own
 units, command opcodes and watchdog figures.
 Assumes inclusion by bare name from the package and the design files.
*/
`ifndef SBC_TIMING_MAP_SVH
`define SBC_TIMING_MAP_SVH

// Clock rate and microsecond tick
`define CLK_MHZ          100
`define US_CYCLES        (`CLK_MHZ * 1)

// Times in microseconds
`define T_STOP_MAX_US    5
`define T_SWITCH_MAX_US  10
`define T_NR2N_MAX_US    10
`define NORMAL_REQUEST_TIMEOUT_US      150000
`define T_RST_US         1000
`define T_WUCS_US        15
`define STUCK_DOMINANT_TIMEOUT_US      1000000
`define BUS_WAKE_FILTER_US      70
`define T_WAKE_STOP_US   13
`define T_WD_DEFAULT_US  150000

// Watchdog resistor law: us = slope * (kohm - offset) + base
`define WD_SLOPE_US      466
`define WD_OFFSET_KOHM   8'h14
`define WD_BASE_US       10000

// Command opcodes, frame bits 7:5
`define CMD_STATUS       3'h0
`define CMD_STOP         3'h1
`define CMD_WD_TRIGGER   3'h2
`define CMD_SWITCH       3'h3
`define CMD_SLEEP        3'h4

// Switch command fields
`define SW_HS_BIT        0
`define SW_LS1_BIT       1
`define SW_LS2_BIT       2
`define SW_PWM_BIT       3

// Serial frame length
`define FRAME_BITS       4'h8

`endif

//--- design/sbc_pkg.sv
/*
 Types of the mode and wake sequencer: modes, watchdog pin codes and the
 state records of both modules.
 Assumes sbc_timing_map.svh is on the include path.
*/
`include "sbc_timing_map.svh"

package sbc_pkg;

	typedef enum logic [2:0] {
		M_RESET = 3'b000,
		M_NREQ  = 3'b001,
		M_NORM  = 3'b010,
		M_STOP  = 3'b011,
		M_WAKE  = 3'b100,
		M_SLEEP = 3'b101
	} mode_t;

	typedef enum logic [1:0] {
		WD_GROUNDED = 2'b00,
		WD_OPEN     = 2'b01,
		WD_RESISTOR = 2'b10
	} wd_cfg_t;

	typedef struct packed {
		logic       cs1;
		logic       cs2;
		logic       cs3;
		logic       sck1;
		logic       sck2;
		logic       sck3;
		logic       mosi1;
		logic       mosi2;
		logic [7:0] shift;
		logic [3:0] cnt;
		logic       frame_valid;
		logic [7:0] frame_data;
		logic       cs_rise;
	} rx_state_t;

	typedef struct packed {
		mode_t       mode;
		logic [6:0]  us_div;
		logic [19:0] mode_tmr;
		logic [17:0] wd_tmr;
		logic [17:0] wd_period;
		logic        wd_on;
		logic [19:0] txd_tmr;
		logic        txd_stuck;
		logic [9:0]  bus_tmr;
		logic        bus_armed;
		logic        wake_pend;
		logic [4:0]  wake_tmr;
		logic        irq_flag;
		logic        hs_en;
		logic        ls1_en;
		logic        ls2_en;
		logic        pwm_sel;
		logic [1:0]  txd_s;
		logic [1:0]  lin_s;
		logic [1:0]  pwm_s;
		logic [1:0]  rstp_s;
		logic [1:0]  wdp1;
		logic [1:0]  wdp2;
		logic [7:0]  res1;
		logic [7:0]  res2;
		logic        irq_n;
		logic        reg_on;
		logic        rst_oe;
		logic        lin_dom;
		logic        hs_out;
		logic [1:0]  ls_out;
	} core_state_t;

endpackage

//--- design/spi_frame_if.sv
/*
 Carrier between the serial receiver and the sequencer core.
 Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps

interface spi_frame_if;
	logic       frame_valid;
	logic [7:0] frame_data;
	logic       cs_rise;

	modport rx   (output frame_valid, output frame_data, output cs_rise);
	modport core (input frame_valid, input frame_data, input cs_rise);
endinterface

//--- design/spi_frame_rx.sv
/*
 Oversampling serial receiver: syncs the chip select, serial clock and data
 pins, shifts data on serial clock rising edges, and reports an eight-bit
 frame and every chip-select rising edge as one-cycle pulses.
 Assumes the serial clock is well below a quarter of clk.
*/
`timescale 1ns/1ps
`include "sbc_timing_map.svh"

module spi_frame_rx
	import sbc_pkg::*;
(
	// Clock and reset
	input  wire logic  clk,
	input  wire logic  rst,
	// Pins
	input  wire logic  cs_n,
	input  wire logic  sclk,
	input  wire logic  mosi,
	// Frames
	spi_frame_if.rx    frm
);
	import sbc_pkg::*;

	rx_state_t s;
	rx_state_t next_s;

	always_comb begin
		next_s = s;
		next_s.cs1 = cs_n;
		next_s.cs2 = s.cs1;
		next_s.cs3 = s.cs2;
		next_s.sck1 = sclk;
		next_s.sck2 = s.sck1;
		next_s.sck3 = s.sck2;
		next_s.mosi1 = mosi;
		next_s.mosi2 = s.mosi1;
		next_s.frame_valid = 1'b0;
		next_s.cs_rise = 1'b0;
		if (!s.cs2 && s.cs3) begin
			next_s.cnt = 4'h0;
		end else if (s.cs2 && !s.cs3) begin
			next_s.cs_rise = 1'b1;
			// A frame counts only if exactly eight bits came in
			if (s.cnt == `FRAME_BITS) begin
				next_s.frame_valid = 1'b1;
				next_s.frame_data = s.shift;
			end
		end else if (!s.cs2 && s.sck2 && !s.sck3) begin
			next_s.shift = {s.shift[6:0], s.mosi2};
			if (s.cnt <= `FRAME_BITS) begin
				next_s.cnt = s.cnt + 4'h1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s <= '0;
			s.cs1 <= 1'b1;
			s.cs2 <= 1'b1;
			s.cs3 <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	assign frm.frame_valid = s.frame_valid;
	assign frm.frame_data  = s.frame_data;
	assign frm.cs_rise     = s.cs_rise;
endmodule

//--- design/sbc_mode_wake_timing.sv
/*
 Mode and wake sequencer of the basis chip: reset hold, Normal Request,
 Normal, Stop, Sleep, wake by chip select or bus, watchdog, switch control,
 stuck-dominant transmit guard and wake interrupt.
 Assumes pins arrive unsynchronised; the reset pin is open drain.
*/
`timescale 1ns/1ps
`include "sbc_timing_map.svh"

module sbc_mode_wake_timing
	import sbc_pkg::*;
#(
	parameter int unsigned NRTOUT_US  = `NORMAL_REQUEST_TIMEOUT_US,
	parameter int unsigned RST_US     = `T_RST_US,
	parameter int unsigned TXDDOM_US  = `STUCK_DOMINANT_TIMEOUT_US,
	parameter int unsigned PROPWL_US  = `BUS_WAKE_FILTER_US,
	parameter int unsigned WD_DEF_US  = `T_WD_DEFAULT_US
)(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// Serial port pins
	input  wire logic        cs_n,
	input  wire logic        sclk,
	input  wire logic        mosi,
	// LIN transceiver
	input  wire logic        txd,
	input  wire logic        lin_rx,
	output logic             lin_tx_dominant,
	// Switches
	input  wire logic        pwm_control_input,
	output logic             high_side_switch,
	output logic [1:0]       low_side_switch,
	// Reset pin, open drain
	input  wire logic        reset_pin_in,
	output logic             reset_pin_out,
	output logic             reset_pin_oe,
	// Watchdog configuration
	input  wire logic [1:0]  watchdog_period_pin,
	input  wire logic [7:0]  period_resistor,
	// Status
	output logic             irq_n,
	output logic             regulator_on,
	output sbc_pkg::mode_t   mode
);
	import sbc_pkg::*;

	localparam logic [6:0] US_LAST = 7'(`US_CYCLES - 1);

	spi_frame_if frm ();

	spi_frame_rx u_rx (
		.clk  (clk),
		.rst  (rst),
		.cs_n (cs_n),
		.sclk (sclk),
		.mosi (mosi),
		.frm  (frm)
	);

	core_state_t s;
	core_state_t next_s;

	logic        tick;
	logic [2:0]  op;
	logic        cmd_ok;
	logic        active;
	logic [7:0]  kohm;
	logic [17:0] wd_law;

	always_comb begin
		next_s = s;
		tick = (s.us_div == US_LAST);
		op = frm.frame_data[7:5];
		// Commands other than status are ignored during reset hold, wake delay and low power
		cmd_ok = frm.frame_valid && (s.mode == M_NREQ || s.mode == M_NORM);
		kohm = (s.res2 < `WD_OFFSET_KOHM) ? 8'h00 : s.res2 - `WD_OFFSET_KOHM;
		wd_law = 18'(18'(kohm) * 18'(`WD_SLOPE_US) + 18'(`WD_BASE_US));

		// Pin synchronisers
		next_s.txd_s = {s.txd_s[0], txd};
		next_s.lin_s = {s.lin_s[0], lin_rx};
		next_s.pwm_s = {s.pwm_s[0], pwm_control_input};
		next_s.rstp_s = {s.rstp_s[0], reset_pin_in};
		next_s.wdp1 = watchdog_period_pin;
		next_s.wdp2 = s.wdp1;
		next_s.res1 = period_resistor;
		next_s.res2 = s.res1;

		next_s.us_div = tick ? 7'h00 : s.us_div + 7'h01;

		// Watchdog configuration
		next_s.wd_on = (wd_cfg_t'(s.wdp2) != WD_GROUNDED);
		next_s.wd_period = (wd_cfg_t'(s.wdp2) == WD_RESISTOR) ? wd_law : 18'(WD_DEF_US);

		// Stuck dominant transmit guard
		if (s.txd_s[1]) begin
			next_s.txd_tmr = 20'h0_0000;
			next_s.txd_stuck = 1'b0;
		end else if (tick && !s.txd_stuck) begin
			next_s.txd_tmr = s.txd_tmr + 20'h0_0001;
			if (s.txd_tmr + 20'h0_0001 >= 20'(TXDDOM_US)) begin
				next_s.txd_stuck = 1'b1;
			end
		end

		// Bus wake filter, low power modes only
		if (s.mode == M_STOP || s.mode == M_SLEEP) begin
			if (!s.lin_s[1]) begin
				if (tick && !s.bus_armed) begin
					next_s.bus_tmr = s.bus_tmr + 10'h001;
					if (s.bus_tmr + 10'h001 >= 10'(PROPWL_US)) begin
						next_s.bus_armed = 1'b1;
					end
				end
			end else begin
				next_s.bus_tmr = 10'h000;
				next_s.bus_armed = 1'b0;
			end
		end else begin
			next_s.bus_tmr = 10'h000;
			next_s.bus_armed = 1'b0;
		end

		if (tick) begin
			next_s.mode_tmr = s.mode_tmr + 20'h0_0001;
			next_s.wd_tmr = s.wd_tmr + 18'h0_0001;
		end

		// Switch and status commands
		if (cmd_ok && op == `CMD_SWITCH) begin
			next_s.hs_en = frm.frame_data[`SW_HS_BIT];
			next_s.ls1_en = frm.frame_data[`SW_LS1_BIT];
			next_s.ls2_en = frm.frame_data[`SW_LS2_BIT];
			next_s.pwm_sel = frm.frame_data[`SW_PWM_BIT];
		end
		if (frm.frame_valid && op == `CMD_STATUS) begin
			next_s.irq_flag = 1'b0;
		end

		case (s.mode)
			M_RESET: begin
				next_s.reg_on = 1'b1;
				if (s.rst_oe && s.mode_tmr >= 20'(RST_US)) begin
					next_s.rst_oe = 1'b0;
				end else if (!s.rst_oe && s.rstp_s[1]) begin
					next_s.mode = M_NREQ;
					next_s.mode_tmr = 20'h0_0000;
				end
			end
			M_NREQ: begin
				if (cmd_ok && op == `CMD_WD_TRIGGER) begin
					next_s.mode = M_NORM;
					next_s.wd_tmr = 18'h0_0000;
				end else if (s.mode_tmr >= 20'(NRTOUT_US)) begin
					next_s.mode = M_RESET;
					next_s.rst_oe = 1'b1;
					next_s.mode_tmr = 20'h0_0000;
				end
			end
			M_NORM: begin
				if (cmd_ok && op == `CMD_WD_TRIGGER) begin
					next_s.wd_tmr = 18'h0_0000;
				end else if (s.wd_on && s.wd_tmr >= s.wd_period) begin
					next_s.mode = M_RESET;
					next_s.rst_oe = 1'b1;
					next_s.mode_tmr = 20'h0_0000;
				end
			end
			M_STOP: begin
				if (frm.cs_rise) begin
					next_s.mode = M_WAKE;
					next_s.mode_tmr = 20'h0_0000;
					next_s.irq_flag = 1'b1;
				end else if (s.wake_pend) begin
					if (tick) begin
						next_s.wake_tmr = s.wake_tmr + 5'h01;
					end
					if (s.wake_tmr >= 5'(`T_WAKE_STOP_US)) begin
						next_s.irq_flag = 1'b1;
						next_s.wake_pend = 1'b0;
						next_s.mode = M_NREQ;
						next_s.mode_tmr = 20'h0_0000;
					end
				end else if (s.bus_armed && s.lin_s[1]) begin
					next_s.wake_pend = 1'b1;
					next_s.wake_tmr = 5'h00;
				end
			end
			M_WAKE: begin
				if (s.mode_tmr >= 20'(`T_WUCS_US)) begin
					next_s.mode = M_NREQ;
					next_s.mode_tmr = 20'h0_0000;
				end
			end
			M_SLEEP: begin
				next_s.reg_on = 1'b0;
				if (s.bus_armed && s.lin_s[1]) begin
					next_s.mode = M_RESET;
					next_s.reg_on = 1'b1;
					next_s.mode_tmr = 20'h0_0000;
				end
			end
			default: begin
				next_s.mode = M_RESET;
				next_s.rst_oe = 1'b1;
				next_s.mode_tmr = 20'h0_0000;
			end
		endcase

		// Low power commands and external reset take precedence
		if (cmd_ok && op == `CMD_STOP) begin
			next_s.mode = M_STOP;
			next_s.wake_pend = 1'b0;
		end else if (cmd_ok && op == `CMD_SLEEP) begin
			next_s.mode = M_SLEEP;
			next_s.rst_oe = 1'b1;
		end
		if (!s.rst_oe && !s.rstp_s[1] && s.mode != M_RESET && s.mode != M_SLEEP) begin
			// Host pulled reset: hold until the pin is released again
			next_s.mode = M_RESET;
			next_s.mode_tmr = 20'h0_0000;
		end

		// Registered outputs
		active = (next_s.mode == M_NREQ || next_s.mode == M_NORM);
		next_s.hs_out = active && next_s.hs_en && (!next_s.pwm_sel || s.pwm_s[1]);
		next_s.ls_out[0] = active && next_s.ls1_en && (!next_s.pwm_sel || s.pwm_s[1]);
		next_s.ls_out[1] = active && next_s.ls2_en && (!next_s.pwm_sel || s.pwm_s[1]);
		next_s.lin_dom = active && !s.txd_s[1] && !next_s.txd_stuck;
		next_s.irq_n = !next_s.irq_flag;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s <= '0;
			s.mode <= M_RESET;
			s.reg_on <= 1'b1;
			s.rst_oe <= 1'b1;
			s.irq_n <= 1'b1;
			s.txd_s <= 2'h3;
			s.lin_s <= 2'h3;
		end else begin
			s <= next_s;
		end
	end

	assign lin_tx_dominant  = s.lin_dom;
	assign high_side_switch = s.hs_out;
	assign low_side_switch  = s.ls_out;
	assign reset_pin_out    = 1'b0;
	assign reset_pin_oe     = s.rst_oe;
	assign irq_n            = s.irq_n;
	assign regulator_on     = s.reg_on;
	assign mode             = s.mode;
endmodule

//--- testbench/sbc_mode_wake_properties.sv
/*
 Timing checks of the mode and wake sequencer, seen from its pins.
 Assumes one clock, synchronous active-high reset, bound into the top module.
*/
`timescale 1ns/1ps

module sbc_mode_wake_properties
	import sbc_pkg::*;
#(
	parameter int unsigned NRTOUT_US = 200,
	parameter int unsigned TXDDOM_US = 300
)(
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// Pins watched
	input  wire logic       cs_n,
	input  wire logic       txd,
	input  wire logic       lin_tx_dominant,
	input  wire logic       high_side_switch,
	input  wire logic [1:0] low_side_switch,
	input  wire logic       reset_pin_oe,
	input  wire logic       irq_n,
	input  wire logic       regulator_on,
	input  sbc_pkg::mode_t  mode
);
	import sbc_pkg::*;
	// Margin covers the microsecond prescaler phase and pin sync
	localparam int NR_LIMIT  = NRTOUT_US * 100 + 200;
	localparam int TXD_LIMIT = TXDDOM_US * 100 + 200;
	logic [12:0] cs_cnt;
	logic [23:0] mode_cnt;
	logic [23:0] txd_cnt;

	always_ff @(posedge clk) begin
		if (rst || $rose(cs_n)) begin
			cs_cnt <= '0;
		end else if (cs_cnt != '1) begin
			cs_cnt <= cs_cnt + 1'h1;
		end
		if (rst || $changed(mode)) begin
			mode_cnt <= '0;
		end else begin
			mode_cnt <= mode_cnt + 1'h1;
		end
		if (rst || txd) begin
			txd_cnt <= '0;
		end else begin
			txd_cnt <= txd_cnt + 1'h1;
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	stop_entry_a: assert property (mode == M_STOP && $past(mode) != M_STOP |-> cs_cnt <= 500)
		else $error("stop mode entered late");
	switch_delay_a: assert property (($changed(high_side_switch) || $changed(low_side_switch)) && $stable(mode)
		|-> cs_cnt <= 1000)
		else $error("switch changed late or without a frame");
	nr_to_norm_a: assert property (mode == M_NORM && $past(mode) == M_NREQ |-> cs_cnt <= 1000)
		else $error("normal mode entered late");
	cs_wake_a: assert property (mode == M_STOP && $rose(cs_n) |-> ##[1:10] mode == M_WAKE)
		else $error("chip select rise did not wake");
	wake_span_a: assert property (mode == M_NREQ && $past(mode) == M_WAKE
		|-> $past(mode_cnt) inside {[899:8000]} && !reset_pin_oe && regulator_on)
		else $error("wake delay out of range");
	irq_clear_a: assert property ($rose(irq_n) |-> cs_cnt <= 20)
		else $error("interrupt released without a read");
	nr_timeout_a: assert property (mode == M_NREQ |-> mode_cnt <= NR_LIMIT)
		else $error("normal request stayed too long");
	stuck_tx_a: assert property (txd_cnt > TXD_LIMIT |-> !lin_tx_dominant)
		else $error("stuck transmit still drives the bus");
endmodule

//--- testbench/host_mcu.sv
/*
 Host model: serial master on chip select, clock and data, plus the
 pulled-up reset wire. Assumes clk is the device clock; changes on its fall.
*/
`timescale 1ns/1ps

module host_mcu (
	// Clock
	input  wire logic clk,
	// Reset wire
	input  wire logic reset_pin_oe,
	output logic      reset_pin_in,
	// Serial port
	output logic      cs_n,
	output logic      sclk,
	output logic      mosi
);
	logic host_rst_n;

	// Pull-up holds the wire high unless the device or the host pulls it
	assign reset_pin_in = ~reset_pin_oe & host_rst_n;
	initial begin
		host_rst_n = 1'h1;
		cs_n = 1'h1;
		sclk = 1'h0;
		mosi = 1'h0;
	end
	task automatic wt(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic send(input logic [7:0] b, input int n);
		cs_n = 1'h0;
		for (int i = 7; i > 7 - n; i--) begin
			mosi = b[i];
			wt(20);
			sclk = 1'h1;
			wt(20);
			sclk = 1'h0;
		end
		wt(20);
		cs_n = 1'h1;
		// Deselected data line toggles so no stale bit is read
		mosi = ~mosi;
		wt(400);
	endtask
	task automatic pulse();
		cs_n = 1'h0;
		wt(50);
		cs_n = 1'h1;
	endtask
	// Host side of the reset wire: on pulls it low
	task automatic hold_reset(input logic on);
		host_rst_n = ~on;
	endtask
endmodule

//--- testbench/tb_top.sv
/*
 Self-checking bench of the mode and wake sequencer with shortened timers.
 Assumes the host model and the property checker are compiled alongside.
*/
`timescale 1ns/1ps

module tb_top;
	import sbc_pkg::*;
	logic       clk;
	logic       rst;
	logic       cs_n;
	logic       sclk;
	logic       mosi;
	logic       txd;
	logic       lin_rx;
	logic       pwm_control_input;
	logic       reset_pin_in;
	logic       reset_pin_oe;
	logic       reset_pin_out;
	logic [1:0] watchdog_period_pin;
	logic [7:0] period_resistor;
	logic       lin_tx_dominant;
	logic       high_side_switch;
	logic [1:0] low_side_switch;
	logic       irq_n;
	logic       regulator_on;
	mode_t      mode;
	int         err_total = 0;
	int         samples_checked = 0;

	sbc_mode_wake_timing #(.NRTOUT_US(200), .RST_US(5), .TXDDOM_US(100), .PROPWL_US(5), .WD_DEF_US(100))
	sbc_mode_wake_timing_i (.clk(clk), .rst(rst), .cs_n(cs_n), .sclk(sclk), .mosi(mosi), .txd(txd),
		.lin_rx(lin_rx), .lin_tx_dominant(lin_tx_dominant), .pwm_control_input(pwm_control_input),
		.high_side_switch(high_side_switch), .low_side_switch(low_side_switch),
		.reset_pin_in(reset_pin_in), .reset_pin_out(reset_pin_out), .reset_pin_oe(reset_pin_oe),
		.watchdog_period_pin(watchdog_period_pin), .period_resistor(period_resistor),
		.irq_n(irq_n), .regulator_on(regulator_on), .mode(mode));
	host_mcu host_mcu_i (.clk(clk), .reset_pin_oe(reset_pin_oe), .reset_pin_in(reset_pin_in),
		.cs_n(cs_n), .sclk(sclk), .mosi(mosi));

	initial begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_total++;
			$display("Error at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	task automatic wus(input int n);
		repeat (n * 100) @(negedge clk);
	endtask
	task automatic wait_mode(input mode_t m, input int us);
		for (int i = 0; i < us * 100; i++) begin
			if (mode === m) break;
			@(negedge clk);
		end
	endtask
	task automatic close_out();
		$display("compares %0d, mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic t_reset();
		chk(mode, M_RESET);
		chk(reset_pin_oe, 1'h1);
		chk(reset_pin_out, 1'h0);
		wait_mode(M_NREQ, 20);
		chk(mode, M_NREQ);
		$display("reset test done");
	endtask
	task automatic t_switch();
		host_mcu_i.send(8'h67, 8);
		wus(6);
		chk({high_side_switch, low_side_switch}, 3'h7);
		host_mcu_i.send(8'h61, 8);
		wus(6);
		chk({high_side_switch, low_side_switch}, 3'h4);
		// Seven-bit frame must be dropped
		host_mcu_i.send(8'h60, 7);
		chk({high_side_switch, low_side_switch}, 3'h4);
		// PWM gate low with gating selected keeps every switch off
		pwm_control_input = 1'h0;
		host_mcu_i.send(8'h6f, 8);
		chk({high_side_switch, low_side_switch}, 3'h0);
		host_mcu_i.send(8'h67, 8);
		chk({high_side_switch, low_side_switch}, 3'h7);
		wus(36);
		pwm_control_input = 1'h1;
		host_mcu_i.send(8'h40, 8);
		wus(6);
		chk(mode, M_NORM);
		$display("switch test done");
	endtask
	task automatic t_stop_wake();
		host_mcu_i.send(8'h20, 8);
		chk(mode, M_STOP);
		host_mcu_i.pulse();
		wus(8);
		chk(mode, M_WAKE);
		chk(irq_n, 1'h0);
		wait_mode(M_NREQ, 72);
		chk(mode, M_NREQ);
		chk(reset_pin_oe, 1'h0);
		wus(90);
		chk(irq_n, 1'h0);
		host_mcu_i.send(8'h00, 8);
		chk(irq_n, 1'h1);
		wait_mode(M_RESET, 250);
		chk(mode, M_RESET);
		chk(reset_pin_oe, 1'h1);
		wait_mode(M_NREQ, 20);
		$display("stop and wake test done");
	endtask
	task automatic t_watchdog();
		watchdog_period_pin = 2'h1;
		host_mcu_i.send(8'h40, 8);
		wus(60);
		host_mcu_i.send(8'h40, 8);
		wus(60);
		chk(mode, M_NORM);
		wait_mode(M_RESET, 100);
		chk(mode, M_RESET);
		wait_mode(M_NREQ, 20);
		watchdog_period_pin = 2'h2;
		host_mcu_i.send(8'h40, 8);
		wus(150);
		chk(mode, M_NORM);
		$display("watchdog test done");
	endtask
	task automatic t_stuck();
		watchdog_period_pin = 2'h0;
		host_mcu_i.send(8'h40, 8);
		txd = 1'h0;
		wus(2);
		chk(lin_tx_dominant, 1'h1);
		wus(105);
		chk(lin_tx_dominant, 1'h0);
		chk(mode, M_NORM);
		txd = 1'h1;
		wus(1);
		txd = 1'h0;
		wus(1);
		chk(lin_tx_dominant, 1'h1);
		txd = 1'h1;
		$display("stuck transmit test done");
	endtask
	task automatic t_bus_wake();
		host_mcu_i.send(8'h20, 8);
		lin_rx = 1'h0;
		wus(2);
		lin_rx = 1'h1;
		wus(30);
		chk(irq_n, 1'h1);
		chk(mode, M_STOP);
		lin_rx = 1'h0;
		wus(6);
		lin_rx = 1'h1;
		wus(8);
		chk(irq_n, 1'h1);
		wus(9);
		chk(irq_n, 1'h0);
		wait_mode(M_NREQ, 5);
		host_mcu_i.send(8'h00, 8);
		host_mcu_i.send(8'h80, 8);
		chk(regulator_on, 1'h0);
		lin_rx = 1'h0;
		wus(6);
		lin_rx = 1'h1;
		wait_mode(M_NREQ, 1500);
		chk(regulator_on, 1'h1);
		chk(mode, M_NREQ);
		$display("bus wake test done");
	endtask
	task automatic t_host_reset();
		host_mcu_i.hold_reset(1'h1);
		wus(1);
		chk(mode, M_RESET);
		chk(reset_pin_oe, 1'h0);
		host_mcu_i.hold_reset(1'h0);
		wus(1);
		chk(mode, M_NREQ);
		$display("host reset test done");
	endtask

	initial begin
		rst = 1'h1;
		txd = 1'h1;
		lin_rx = 1'h1;
		pwm_control_input = 1'h1;
		watchdog_period_pin = 2'h0;
		period_resistor = 8'h14;
		repeat (2) @(negedge clk);
		rst = 1'h0;
		t_reset();
		t_switch();
		t_stop_wake();
		t_watchdog();
		t_stuck();
		t_bus_wake();
		t_host_reset();
		close_out();
	end

	// Whole run is near 0.9 ms; well past that means a hang
	initial begin
		#1_200_000;
		err_total++;
		close_out();
	end
endmodule

bind sbc_mode_wake_timing sbc_mode_wake_properties #(.NRTOUT_US(NRTOUT_US), .TXDDOM_US(TXDDOM_US))
	props_i (.clk(clk), .rst(rst), .cs_n(cs_n), .txd(txd), .lin_tx_dominant(lin_tx_dominant),
	.high_side_switch(high_side_switch), .low_side_switch(low_side_switch), .reset_pin_oe(reset_pin_oe),
	.irq_n(irq_n), .regulator_on(regulator_on), .mode(mode));
